/* rtl/compact_timer_unit.sv */
// compact 10-bit timer with register port
//
// How it works
// - pause bit set holds the count; clearing resumes from held value
// - clock select picks sys/4, sys, high/16, high/64 or sub tick
// - on bit set lets counter run; clear stops it
// - on bit rise zeroes the counter; fall keeps residual value
// - on bit rise returns output to initial level in compare mode
// - period code matches counter bits 9..7, steps of 128 clocks
// - period code zero lets the counter overflow as the clear
// - mode field: 00 compare, 10 pwm, 11 timer; 01 undefined
// - compare mode A match does none, low, high or toggle
// - pwm action: inactive, active, waveform; 11 undefined
// - compare mode initial level is the output control bit
// - pwm output control bit picks active high or low
// - action equal to current level gives no visible change
// - invert bit flips output, no effect in timer mode
// - swap bit exchanges period and duty comparators in pwm
// - clear source: A match, or P match and overflow
// - pwm mode ignores the clear source bit
// - counter readable as low byte and high bits 9..8
// - unused high byte bits read zero
// - timer mode output undefined, output control ignored
// - low byte goes through buffer, committed or latched by high byte access
// - outside pwm, A clearing gives no P flag; output follows A flag only
// - pwm duty at or above period gives constant active output
// - complementary output is the inverse of the main output
`timescale 1ns/1ps
`include "ctm_consts.svh"

module compact_timer_unit
  import ctm_pkg::*;
#(
  parameter int CNT_W = 10,
  parameter int SUB_DIV = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic high_clk_tick,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic timer_out,
  output logic timer_out_n,
  output logic match_a_flag,
  output logic match_p_flag
);

  initial begin
    if (CNT_W != 10 || SUB_DIV < 2 || SUB_DIV > 255) begin
      $error("unsupported parameter value");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] ctrl_a_r;
  logic [7:0] ctrl_b_r;
  logic [9:0] compare_a_value_r;
  logic [7:0] low_buf_r;
  logic [9:0] count_r;
  logic [9:0] count_nxt;
  logic out_r;
  logic on_d_r;
  logic [7:0] sys_div_r;
  logic [7:0] h_div_r;
  logic [7:0] sub_div_r;

  logic count_hold;
  logic timer_on;
  clk_sel_t clk_source_sel;
  logic [2:0] period_cmp_bits;
  op_mode_t op_mode_sel;
  out_action_t out_action_sel;
  logic out_initial_level;
  logic out_invert;
  logic duty_period_swap;
  logic clear_source_sel;

  assign count_hold = ctrl_a_r[`BIT_HOLD];
  assign clk_source_sel = clk_sel_t'(ctrl_a_r[`BIT_CLK_HI:`BIT_CLK_LO]);
  assign timer_on = ctrl_a_r[`BIT_ON];
  assign period_cmp_bits = ctrl_a_r[`BIT_PER_HI:`BIT_PER_LO];
  assign op_mode_sel = op_mode_t'(ctrl_b_r[`BIT_MODE_HI:`BIT_MODE_LO]);
  assign out_action_sel = out_action_t'(ctrl_b_r[`BIT_ACT_HI:`BIT_ACT_LO]);
  assign out_initial_level = ctrl_b_r[`BIT_INIT];
  assign out_invert = ctrl_b_r[`BIT_INV];
  assign duty_period_swap = ctrl_b_r[`BIT_SWAP];
  assign clear_source_sel = ctrl_b_r[`BIT_CLR_SRC];

  // mode and action changes are only safe with the timer off; not policed here
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_a_r <= `CTRL_A_RESET;
      ctrl_b_r <= `CTRL_B_RESET;
    end else if (wr && addr == `OFS_CTRL_A) begin
      ctrl_a_r <= wdata;
    end else if (wr && addr == `OFS_CTRL_B) begin
      ctrl_b_r <= wdata;
    end
  end

  // low byte buffer shared by both pairs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      low_buf_r <= 8'h00;
      compare_a_value_r <= `CMPA_RESET;
    end else if (wr && addr == `OFS_CMPA_LOW) begin
      low_buf_r <= wdata;
    end else if (wr && addr == `OFS_CMPA_HIGH) begin
      compare_a_value_r <= {wdata[1:0], low_buf_r};
    end else if (rd && addr == `OFS_COUNT_HIGH) begin
      low_buf_r <= count_r[7:0];
    end else if (rd && addr == `OFS_CMPA_HIGH) begin
      low_buf_r <= compare_a_value_r[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `OFS_CTRL_A: rdata <= ctrl_a_r;
        `OFS_CTRL_B: rdata <= ctrl_b_r;
        `OFS_COUNT_LOW: rdata <= low_buf_r;
        `OFS_COUNT_HIGH: rdata <= {6'h00, count_r[9:8]};
        `OFS_CMPA_LOW: rdata <= low_buf_r;
        `OFS_CMPA_HIGH: rdata <= {6'h00, compare_a_value_r[9:8]};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter clock tick

  function automatic logic [7:0] div_step(input logic [7:0] cnt, input logic adv, input logic [7:0] lim);
    if (!adv) begin
      div_step = cnt;
    end else if (cnt >= lim - 8'd1) begin
      div_step = 8'h00;
    end else begin
      div_step = cnt + 8'd1;
    end
  endfunction : div_step

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sys_div_r <= 8'h00;
      h_div_r <= 8'h00;
      sub_div_r <= 8'h00;
    end else begin
      sys_div_r <= div_step(sys_div_r, 1'b1, `DIV_SYS4);
      h_div_r <= div_step(h_div_r, high_clk_tick, `DIV_H64);
      sub_div_r <= div_step(sub_div_r, 1'b1, 8'(SUB_DIV));
    end
  end

  logic tick;
  always_comb begin
    case (clk_source_sel)
      CK_SYS4: tick = (sys_div_r == 8'h00);
      CK_SYS: tick = 1'b1;
      CK_H16: tick = high_clk_tick && (h_div_r[3:0] == 4'h0);
      CK_H64: tick = high_clk_tick && (h_div_r == 8'h00);
      CK_SUB0, CK_SUB1: tick = (sub_div_r == 8'h00);
      default: tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparators and counter

  logic on_rise;
  logic run;
  logic match_a;
  logic match_p;
  logic overflow;
  logic clr_by_a;
  logic clr_now;
  logic p_clears;

  assign on_rise = timer_on && !on_d_r;
  assign run = timer_on && !count_hold && tick;
  assign match_a = run && (count_r == compare_a_value_r) && (compare_a_value_r != 10'h000);
  assign match_p = run && (period_cmp_bits != 3'h0) &&
                   (count_r == {period_cmp_bits - 3'h1, 7'h7F});
  assign overflow = run && (count_r == 10'h3FF);
  // pwm clears on the period comparator; swap picks which one
  assign clr_by_a = (op_mode_sel == MODE_PWM) ? duty_period_swap : clear_source_sel;
  assign p_clears = match_p || (overflow && period_cmp_bits == 3'h0);
  assign clr_now = clr_by_a ? (match_a || overflow) : p_clears;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      on_d_r <= 1'b0;
    end else begin
      on_d_r <= timer_on;
    end
  end

  always_comb begin
    if (on_rise) begin
      count_nxt = 10'h000;
    end else if (clr_now) begin
      count_nxt = 10'h000;
    end else if (run) begin
      count_nxt = count_r + 10'd1;
    end else begin
      count_nxt = count_r;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count_r <= 10'h000;
    end else begin
      count_r <= count_nxt;
    end
  end

  // match flags are one-cycle pulses
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      match_a_flag <= 1'b0;
      match_p_flag <= 1'b0;
    end else begin
      match_a_flag <= match_a;
      match_p_flag <= (clr_by_a && op_mode_sel != MODE_PWM) ? 1'b0 : p_clears;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output

  logic [10:0] period_len;
  logic [10:0] duty_len;
  logic pwm_active;
  logic out_level;
  logic out_pin;

  assign period_len = duty_period_swap ? {1'b0, compare_a_value_r} :
                      ((period_cmp_bits == 3'h0) ? 11'h400 : {1'b0, period_cmp_bits, 7'h00});
  assign duty_len = duty_period_swap ?
                    ((period_cmp_bits == 3'h0) ? 11'h400 : {1'b0, period_cmp_bits, 7'h00}) :
                    {1'b0, compare_a_value_r};
  assign pwm_active = (duty_len >= period_len) || ({1'b0, count_r} < duty_len);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      out_r <= 1'b0;
    end else if (on_rise) begin
      out_r <= out_initial_level;
    end else if (op_mode_sel == MODE_CMP && match_a) begin
      case (out_action_sel)
        ACT_NONE: out_r <= out_r;
        ACT_LOW: out_r <= 1'b0;
        ACT_HIGH: out_r <= 1'b1;
        ACT_TOGGLE: out_r <= !out_r;
        default: out_r <= out_r;
      endcase
    end
  end

  always_comb begin
    case (op_mode_sel)
      MODE_CMP: out_level = out_r ^ out_invert;
      MODE_PWM: begin
        case (out_action_sel)
          ACT_NONE: out_level = !out_initial_level;
          ACT_LOW: out_level = out_initial_level;
          ACT_HIGH: out_level = pwm_active ~^ out_initial_level;
          default: out_level = 1'b0;
        endcase
        out_level = out_level ^ out_invert;
      end
      default: out_level = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      out_pin <= 1'b0;
    end else begin
      out_pin <= out_level;
    end
  end

  assign timer_out = out_pin;
  assign timer_out_n = !out_pin;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_on_rise_zero: assert property (@(posedge clock) disable iff (!rst_n)
    on_rise |=> count_r == 10'h000)
    else $error("counter not zeroed on turn-on");

  a_hold_keeps: assert property (@(posedge clock) disable iff (!rst_n)
    (count_hold && !on_rise) |=> $stable(count_r))
    else $error("counter moved while held");

  a_off_keeps: assert property (@(posedge clock) disable iff (!rst_n)
    !timer_on |=> $stable(count_r))
    else $error("counter moved while off");

  a_run_step: assert property (@(posedge clock) disable iff (!rst_n)
    (run && !clr_now && !on_rise) |=> count_r == $past(count_r) + 10'd1)
    else $error("bad count step");

  a_p_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (p_clears && !clr_by_a) |=> count_r == 10'h000)
    else $error("p match did not clear");

  a_no_p_flag: assert property (@(posedge clock) disable iff (!rst_n)
    (clear_source_sel && op_mode_sel == MODE_CMP) |=> !match_p_flag)
    else $error("p flag with a clear");

  a_init_level: assert property (@(posedge clock) disable iff (!rst_n)
    on_rise |=> out_r == $past(out_initial_level))
    else $error("initial level not applied");

  a_comp_out: assert property (@(posedge clock) disable iff (!rst_n)
    1'b1 |-> timer_out_n == !timer_out)
    else $error("complement output wrong");

  a_high_zero: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rd) && ($past(addr) == `OFS_COUNT_HIGH) |-> rdata[7:2] == 6'h00)
    else $error("high bits not zero");

  a_rd_idle: assert property (@(posedge clock) disable iff (!rst_n)
    !$past(rd) |-> rdata == 8'h00)
    else $error("read data outside read slot");

  a_clr_a: assert property (@(posedge clock) disable iff (!rst_n)
    (clr_by_a && match_a) |=> count_r == 10'h000)
    else $error("a match did not clear");

  a_pwm_full: assert property (@(posedge clock) disable iff (!rst_n)
    (op_mode_sel == MODE_PWM && out_action_sel == ACT_HIGH && duty_len >= period_len) |=>
    timer_out == ($past(out_initial_level) ^ $past(out_invert)))
    else $error("full duty not active");

  a_tmr_out: assert property (@(posedge clock) disable iff (!rst_n)
    op_mode_sel == MODE_TMR |=> !timer_out)
    else $error("timer mode output not low");

  a_buf_commit: assert property (@(posedge clock) disable iff (!rst_n)
    (wr && addr == `OFS_CMPA_HIGH) |=> compare_a_value_r == {$past(wdata[1:0]), $past(low_buf_r)})
    else $error("compare value not committed");

  a_bad_clk: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_source_sel == CK_BAD0 || clk_source_sel == CK_BAD1) |-> !run)
    else $error("counting on undefined clock");

  a_sys4_gap: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_source_sel == CK_SYS4 && tick && !(wr && addr == `OFS_CTRL_A)) |=> !tick)
    else $error("divided tick too fast");

  a_pwm_idle: assert property (@(posedge clock) disable iff (!rst_n)
    (op_mode_sel == MODE_PWM && out_action_sel == ACT_NONE) |=>
    timer_out == !($past(out_initial_level) ^ $past(out_invert)))
    else $error("inactive level wrong");

  a_cmp_keep: assert property (@(posedge clock) disable iff (!rst_n)
    (op_mode_sel == MODE_CMP && !match_a && !on_rise) |=> $stable(out_r))
    else $error("output moved without a match");

endmodule : compact_timer_unit

/* rtl/ctm_consts.svh */
// register offsets, field positions, reset values and timing counts
`ifndef CTM_CONSTS_SVH
`define CTM_CONSTS_SVH
`define OFS_CTRL_A 3'h0
`define OFS_CTRL_B 3'h1
`define OFS_COUNT_LOW 3'h2
`define OFS_COUNT_HIGH 3'h3
`define OFS_CMPA_LOW 3'h4
`define OFS_CMPA_HIGH 3'h5
`define CTRL_A_RESET 8'h00
`define CTRL_B_RESET 8'h00
`define CMPA_RESET 10'h000
`define BIT_HOLD 7
`define BIT_CLK_HI 6
`define BIT_CLK_LO 4
`define BIT_ON 3
`define BIT_PER_HI 2
`define BIT_PER_LO 0
`define BIT_MODE_HI 7
`define BIT_MODE_LO 6
`define BIT_ACT_HI 5
`define BIT_ACT_LO 4
`define BIT_INIT 3
`define BIT_INV 2
`define BIT_SWAP 1
`define BIT_CLR_SRC 0
`define DIV_SYS4 8'd4
`define DIV_H16 8'd16
`define DIV_H64 8'd64
`endif

/* rtl/ctm_pkg.sv */
// types of the compact timer
package ctm_pkg;
  typedef enum logic [1:0] {MODE_CMP = 2'h0, MODE_UNDEF = 2'h1, MODE_PWM = 2'h2, MODE_TMR = 2'h3} op_mode_t;
  typedef enum logic [1:0] {ACT_NONE = 2'h0, ACT_LOW = 2'h1, ACT_HIGH = 2'h2, ACT_TOGGLE = 2'h3} out_action_t;
  typedef enum logic [2:0] {CK_SYS4 = 3'h0, CK_SYS = 3'h1, CK_H16 = 3'h2, CK_H64 = 3'h3,
                            CK_SUB0 = 3'h4, CK_SUB1 = 3'h5, CK_BAD0 = 3'h6, CK_BAD1 = 3'h7} clk_sel_t;
endpackage : ctm_pkg

/* testbench/testbench.sv */
// self-checking bench for the compact timer
`timescale 1ns/1ps
`include "ctm_consts.svh"
module testbench
  import ctm_pkg::*;
;
  typedef struct {logic [7:0] cb; logic [9:0] ca; bit p; int win; int hi;} pwm_row_t;
  logic clock, rst_n, tick, wr, rd, timer_out, timer_out_n, match_a_flag, match_p_flag;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, v, v2;
  int failures, n_compared, n, np, hi;
  int per[6] = '{44, 11, 352, 1408, 88, 88};
  pwm_row_t rows[7] = '{'{8'hA8, 10'd200, 1, 128, 128}, '{8'hA8, 10'd32, 1, 128, 32}, '{8'hA0, 10'd32, 1, 128, 96},
    '{8'hAC, 10'd32, 1, 128, 96}, '{8'h98, 10'd32, 1, 128, 128}, '{8'h88, 10'd32, 1, 128, 0},
    '{8'hAA, 10'd32, 0, 66, 66}};
  compact_timer_unit DUT (.clock(clock), .rst_n(rst_n), .high_clk_tick(tick), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .timer_out(timer_out), .timer_out_n(timer_out_n),
    .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial tick = 1'b0;
  always @(posedge clock) tick <= ~tick;
  always @(negedge clock) begin
    np = np + (match_p_flag === 1'b1);
    hi = hi + (timer_out === 1'b1);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8
  task automatic chkn(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkn
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    d = rdata;
  endtask : rd_reg
  task automatic rd_count(output logic [7:0] d);
    logic [7:0] h;
    rd_reg(`OFS_COUNT_HIGH, h);
    rd_reg(`OFS_COUNT_LOW, d);
  endtask : rd_count
  task automatic start(input logic [7:0] ca);
    wr_reg(`OFS_CTRL_A, ca & 8'hF7);
    wr_reg(`OFS_CTRL_A, ca);
  endtask : start
  task automatic set_cmpa(input logic [9:0] c);
    wr_reg(`OFS_CMPA_LOW, c[7:0]);
    wr_reg(`OFS_CMPA_HIGH, {6'h00, c[9:8]});
  endtask : set_cmpa
  task automatic wait_flag(input bit p, output int k);
    k = 0;
    while ((p ? match_p_flag : match_a_flag) !== 1'b1) begin
      @(negedge clock);
      k++;
      if (k > 4000) begin
        failures++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, 0, 1);
        tally_and_finish();
      end
    end
  endtask : wait_flag
  task automatic period_of(input bit p, output int c);
    wait_flag(p, c);
    @(negedge clock);
    wait_flag(p, c);
    c = c + 1;
  endtask : period_of
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    failures = 0;
    n_compared = 0;
    np = 0;
    hi = 0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    // reset values, read-only and unmapped places
    wr_reg(`OFS_COUNT_HIGH, 8'hFF);
    wr_reg(3'h7, 8'hFF);
    foreach (per[i]) begin
      rd_reg(i[2:0], v);
      chk8(v, 8'h00);
    end
    set_cmpa(10'h234);
    rd_reg(`OFS_CMPA_HIGH, v);
    chk8(v, 8'h02);
    rd_reg(`OFS_CMPA_LOW, v);
    chk8(v, 8'h34);
    $display("test registers done");
    // clock sources, compare A clearing, no P flags
    set_cmpa(10'd10);
    wr_reg(`OFS_CTRL_B, 8'h31);
    np = 0;
    for (int i = 0; i < 6; i++) begin
      start({1'b0, i[2:0], 4'h8});
      period_of(0, n);
      chkn(n, per[i]);
    end
    chkn(np, 0);
    // compare output actions, initial level, polarity
    for (int j = 0; j < 16; j++) begin
      wr_reg(`OFS_CTRL_B, {2'b00, j[1:0], j[2], j[3], 2'b01});
      start(8'h18);
      repeat (3) @(negedge clock);
      chk8({7'h00, timer_out}, {7'h00, j[2] ^ j[3]});
      wait_flag(0, n);
      repeat (3) @(negedge clock);
      v = {7'h00, (j[1:0] == 2'd0) ? j[2] : (j[1:0] == 2'd3) ? ~j[2] : j[1]} ^ {7'h00, j[3]};
      chk8({7'h00, timer_out}, v);
      chk8({7'h00, timer_out_n}, v ^ 8'h01);
    end
    wr_reg(`OFS_CTRL_A, 8'h10);
    wr_reg(`OFS_CTRL_B, 8'hFD);
    start(8'h18);
    repeat (20) @(negedge clock);
    chk8({7'h00, timer_out}, 8'h00);
    $display("test compare mode done");
    // pause, off and on edges
    wr_reg(`OFS_CTRL_A, 8'h10);
    wr_reg(`OFS_CTRL_B, 8'h00);
    start(8'h18);
    repeat (20) @(posedge clock);
    wr_reg(`OFS_CTRL_A, 8'h98);
    rd_count(v);
    repeat (10) @(posedge clock);
    rd_count(v2);
    chk8(v2, v);
    wr_reg(`OFS_CTRL_A, 8'h18);
    rd_count(v2);
    chk8({7'h00, v2 > v}, 8'h01);
    wr_reg(`OFS_CTRL_A, 8'h10);
    rd_count(v);
    repeat (10) @(posedge clock);
    rd_count(v2);
    chk8(v2, v);
    wr_reg(`OFS_CTRL_A, 8'h98);
    rd_count(v);
    chk8(v, 8'h00);
    // period comparator and overflow
    for (int c = 0; c < 3; c++) begin
      start({5'h03, c[2:0]});
      period_of(1, n);
      chkn(n, (c == 0) ? 1024 : c * 128);
    end
    $display("test counter done");
    // pwm levels, duty and swap, clear source bit left at zero
    foreach (rows[r]) begin
      wr_reg(`OFS_CTRL_A, 8'h11);
      wr_reg(`OFS_CTRL_B, rows[r].cb);
      set_cmpa(rows[r].ca);
      wr_reg(`OFS_CTRL_A, 8'h19);
      wait_flag(rows[r].p, n);
      hi = 0;
      repeat (rows[r].win) @(negedge clock);
      chkn(hi, rows[r].hi);
    end
    $display("test pwm done");
    tally_and_finish();
  end
endmodule : testbench
